// file: common/lecs_pkg.sv
// Constants shared by the lane error count and status block
package lecs_pkg;

  // ***********************************************************
  // Structure
  // ***********************************************************
  localparam int LECS_LANES     = 8;
  localparam int LECS_LINKS     = 2;
  localparam int LECS_ERR_TYPES = 3;
  localparam int LECS_CNT_W     = 8;
  localparam int LECS_LN_TOT    = LECS_LINKS * LECS_LANES;

  // ***********************************************************
  // Counter values
  // ***********************************************************
  localparam logic [LECS_CNT_W-1:0] LECS_TERM_CNT = 8'hff;
  localparam logic [LECS_CNT_W-1:0] LECS_CNT_ZERO = 8'h00;
  localparam logic [LECS_CNT_W-1:0] LECS_CNT_ONE  = 8'h01;

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  localparam int LECS_ADDR_W  = 16;
  localparam int LECS_DATA_W  = 32;
  localparam int LECS_IDX_W   = 12;
  localparam int LECS_IDX_LSB = 2;
  localparam int LECS_IDX_MSB = 13;

  // Register indexes, byte address is four times the index
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_LINK_PAGE = 12'h300;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_THRESH    = 12'h301;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_HOLD      = 12'h302;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_CNT_CLR   = 12'h303;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_IRQ_STAT  = 12'h304;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_IRQ_MASK  = 12'h305;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_LANE6     = 12'h496;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_LANE7     = 12'h497;
  localparam logic [LECS_IDX_W-1:0] LECS_IDX_HEALTH0   = 12'h4b0;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int LECS_ERR_DISP    = 0;
  localparam int LECS_ERR_INVAL   = 1;
  localparam int LECS_ERR_STRAY   = 2;
  localparam int LECS_LANE_EN_BIT = 3;
  localparam int LECS_H_DISP_BIT  = 7;
  localparam int LECS_H_INVAL_BIT = 6;
  localparam int LECS_H_STRAY_BIT = 5;
  localparam int LECS_LANE6       = 6;
  localparam int LECS_LANE7       = 7;
  localparam int LECS_LANE0       = 0;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic                  LECS_PAGE_RST   = 1'b0;
  localparam logic [LECS_CNT_W-1:0] LECS_THRESH_RST = 8'hff;
  localparam logic [2:0]            LECS_HOLD_RST   = 3'h0;
  localparam logic [2:0]            LECS_IRQ_RST    = 3'h0;
  localparam logic [LECS_DATA_W-1:0] LECS_DATA_ZERO = 32'h0000_0000;

endpackage

// file: hw/lecs_err_counter.sv
// One 8-bit error counter with terminal count flag
`timescale 1ns/1ps
module lecs_err_counter
  import lecs_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  err_evt,
  input  wire logic                  cnt_clr,
  input  wire logic                  hold_at_term,
  // Status
  output logic [LECS_CNT_W-1:0]      cnt_reg,
  output logic                       term_flag_reg,
  output logic                       term_hit
);

  logic [LECS_CNT_W-1:0] base_cnt;
  logic [LECS_CNT_W-1:0] cnt_next;
  logic                  term_flag_next;

  // ***********************************************************
  // Next count
  // ***********************************************************
  always_comb
  begin
    base_cnt = cnt_clr ? LECS_CNT_ZERO : cnt_reg;
    cnt_next = base_cnt;
    term_hit = 1'b0;
    if (err_evt)
    begin
      if (base_cnt == LECS_TERM_CNT)
        cnt_next = hold_at_term ? LECS_TERM_CNT : LECS_CNT_ZERO;
      else
        cnt_next = base_cnt + LECS_CNT_ONE;
      term_hit = (cnt_next == LECS_TERM_CNT) && (base_cnt != LECS_TERM_CNT);
    end
    term_flag_next = cnt_clr ? 1'b0 : term_flag_reg;
    if (term_hit)
      term_flag_next = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cnt_reg <= LECS_CNT_ZERO;
    else
      cnt_reg <= cnt_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      term_flag_reg <= 1'b0;
    else
      term_flag_reg <= term_flag_next;
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  term_flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
    (cnt_reg == LECS_TERM_CNT) |-> term_flag_reg)
    else $error("Counter at terminal count without flag");

  hold_freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    (hold_at_term && cnt_reg == LECS_TERM_CNT && !cnt_clr) |=> (cnt_reg == LECS_TERM_CNT))
    else $error("Held counter left terminal count");

  wrap_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (!hold_at_term && cnt_reg == LECS_TERM_CNT && err_evt && !cnt_clr) |=> (cnt_reg == LECS_CNT_ZERO))
    else $error("Counter did not roll over to zero");

  incr_one_a: assert property (@(posedge core_clk) disable iff (rst)
    (err_evt && !cnt_clr && cnt_reg != LECS_TERM_CNT) |=> (cnt_reg == $past(cnt_reg) + LECS_CNT_ONE))
    else $error("Counter did not step by one");

  clear_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (cnt_clr && !err_evt) |=> (cnt_reg == LECS_CNT_ZERO && !term_flag_reg))
    else $error("Counter not cleared by user reset");

endmodule // lecs_err_counter

// file: hw/lecs_lane_status.sv
// Lane error counters, paged status registers and APB slave
`timescale 1ns/1ps
module lecs_lane_status
  import lecs_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [LECS_ADDR_W-1:0]   paddr,
  input  wire logic [LECS_DATA_W-1:0]   pwdata,
  output logic [LECS_DATA_W-1:0]        prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Lane events, index link*8+lane
  input  wire logic [LECS_LN_TOT-1:0]   running_disparity_error,
  input  wire logic [LECS_LN_TOT-1:0]   invalid_code_group_error,
  input  wire logic [LECS_LN_TOT-1:0]   unexpected_control_char_error,
  input  wire logic [LECS_LN_TOT-1:0]   lane_enabled_in,
  // Interrupt
  output logic                          irq
);

  // ***********************************************************
  // Declarations
  // ***********************************************************
  logic                    link_page_reg;
  logic [LECS_CNT_W-1:0]   error_threshold_reg;
  logic [2:0]              counter_hold_at_terminal_reg;
  logic [2:0]              irq_stat_reg;
  logic [2:0]              irq_mask_reg;
  logic [LECS_DATA_W-1:0]  prdata_reg;
  logic [LECS_DATA_W-1:0]  rd_next;

  logic [LECS_IDX_W-1:0]   reg_idx;
  logic                    addr_ok;
  logic                    setup_ph;
  logic                    access_ph;
  logic                    wr_stb;
  logic [2:0]              clr_req;
  logic [2:0]              irq_set;

  logic [LECS_CNT_W-1:0]   cnt_val  [LECS_LINKS][LECS_LANES][LECS_ERR_TYPES];
  logic [2:0]              tc_flag  [LECS_LINKS][LECS_LANES];
  logic [LECS_LN_TOT-1:0]  hit_vec  [LECS_ERR_TYPES];
  logic [LECS_LN_TOT-1:0]  evt_vec  [LECS_ERR_TYPES];

  logic [7:0]              lane6_counter_status;
  logic [7:0]              lane7_counter_status;
  logic [7:0]              lane0_link_health;
  logic                    lane6_enabled_flag;
  logic                    lane7_enabled_flag;
  logic [2:0]              lane6_terminal_count_flags;
  logic [2:0]              lane7_terminal_count_flags;
  logic                    lane0_disparity_over_threshold;
  logic                    lane0_invalid_code_over_threshold;
  logic                    lane0_stray_control_over_threshold;

  // ***********************************************************
  // Error counters
  // ***********************************************************
  assign evt_vec[LECS_ERR_DISP]  = running_disparity_error;
  assign evt_vec[LECS_ERR_INVAL] = invalid_code_group_error;
  assign evt_vec[LECS_ERR_STRAY] = unexpected_control_char_error;

  for (genvar lk = 0; lk < LECS_LINKS; lk++)
  begin : g_link
    for (genvar ln = 0; ln < LECS_LANES; ln++)
    begin : g_lane
      for (genvar et = 0; et < LECS_ERR_TYPES; et++)
      begin : g_type
        lecs_err_counter u_cnt
        (
          .core_clk      (core_clk),
          .rst           (rst),
          .err_evt       (evt_vec[et][lk*LECS_LANES+ln]),
          .cnt_clr       (clr_req[et] && (link_page_reg == 1'(lk))),
          .hold_at_term  (counter_hold_at_terminal_reg[et]),
          .cnt_reg       (cnt_val[lk][ln][et]),
          .term_flag_reg (tc_flag[lk][ln][et]),
          .term_hit      (hit_vec[et][lk*LECS_LANES+ln])
        );
      end
    end
  end

  // ***********************************************************
  // Paged status views
  // ***********************************************************
  assign lane6_enabled_flag         = lane_enabled_in[{link_page_reg, 3'(LECS_LANE6)}];
  assign lane7_enabled_flag         = lane_enabled_in[{link_page_reg, 3'(LECS_LANE7)}];
  assign lane6_terminal_count_flags = tc_flag[link_page_reg][LECS_LANE6];
  assign lane7_terminal_count_flags = tc_flag[link_page_reg][LECS_LANE7];

  assign lane0_disparity_over_threshold =
    cnt_val[link_page_reg][LECS_LANE0][LECS_ERR_DISP] >= error_threshold_reg;
  assign lane0_invalid_code_over_threshold =
    cnt_val[link_page_reg][LECS_LANE0][LECS_ERR_INVAL] >= error_threshold_reg;
  assign lane0_stray_control_over_threshold =
    cnt_val[link_page_reg][LECS_LANE0][LECS_ERR_STRAY] >= error_threshold_reg;

  always_comb
  begin
    lane6_counter_status                   = 8'h00;
    lane6_counter_status[LECS_LANE_EN_BIT] = lane6_enabled_flag;
    lane6_counter_status[2:0]              = lane6_terminal_count_flags;
    lane7_counter_status                   = 8'h00;
    lane7_counter_status[LECS_LANE_EN_BIT] = lane7_enabled_flag;
    lane7_counter_status[2:0]              = lane7_terminal_count_flags;
    lane0_link_health                      = 8'h00;
    lane0_link_health[LECS_H_DISP_BIT]     = lane0_disparity_over_threshold;
    lane0_link_health[LECS_H_INVAL_BIT]    = lane0_invalid_code_over_threshold;
    lane0_link_health[LECS_H_STRAY_BIT]    = lane0_stray_control_over_threshold;
  end

  // ***********************************************************
  // APB decode
  // ***********************************************************
  assign reg_idx   = paddr[LECS_IDX_MSB:LECS_IDX_LSB];
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;

  always_comb
  begin
    addr_ok = 1'b0;
    rd_next = LECS_DATA_ZERO;
    unique case (reg_idx)
      LECS_IDX_LINK_PAGE:
      begin
        addr_ok    = 1'b1;
        rd_next[0] = link_page_reg;
      end
      LECS_IDX_THRESH:
      begin
        addr_ok                 = 1'b1;
        rd_next[LECS_CNT_W-1:0] = error_threshold_reg;
      end
      LECS_IDX_HOLD:
      begin
        addr_ok      = 1'b1;
        rd_next[2:0] = counter_hold_at_terminal_reg;
      end
      LECS_IDX_CNT_CLR:
        addr_ok = 1'b1;
      LECS_IDX_IRQ_STAT:
      begin
        addr_ok      = 1'b1;
        rd_next[2:0] = irq_stat_reg;
      end
      LECS_IDX_IRQ_MASK:
      begin
        addr_ok      = 1'b1;
        rd_next[2:0] = irq_mask_reg;
      end
      LECS_IDX_LANE6:
      begin
        addr_ok      = 1'b1;
        rd_next[7:0] = lane6_counter_status;
      end
      LECS_IDX_LANE7:
      begin
        addr_ok      = 1'b1;
        rd_next[7:0] = lane7_counter_status;
      end
      LECS_IDX_HEALTH0:
      begin
        addr_ok      = 1'b1;
        rd_next[7:0] = lane0_link_health;
      end
      default:
        addr_ok = 1'b0;
    endcase
    if (paddr[LECS_IDX_LSB-1:0] != 2'b00 || paddr[LECS_ADDR_W-1:LECS_IDX_MSB+1] != 2'b00)
    begin
      addr_ok = 1'b0;
      rd_next = LECS_DATA_ZERO;
    end
  end

  assign wr_stb  = access_ph && pwrite && addr_ok;
  assign pready  = 1'b1;
  assign pslverr = access_ph && !addr_ok;
  assign prdata  = prdata_reg;
  assign clr_req = (wr_stb && reg_idx == LECS_IDX_CNT_CLR) ? pwdata[2:0] : 3'h0;

  // ***********************************************************
  // Read data
  // ***********************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      prdata_reg <= LECS_DATA_ZERO;
    else if (setup_ph && !pwrite)
      prdata_reg <= rd_next;
  end

  // ***********************************************************
  // Control registers
  // ***********************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      link_page_reg <= LECS_PAGE_RST;
    else if (wr_stb && reg_idx == LECS_IDX_LINK_PAGE)
      link_page_reg <= pwdata[0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      error_threshold_reg <= LECS_THRESH_RST;
    else if (wr_stb && reg_idx == LECS_IDX_THRESH)
      error_threshold_reg <= pwdata[LECS_CNT_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      counter_hold_at_terminal_reg <= LECS_HOLD_RST;
    else if (wr_stb && reg_idx == LECS_IDX_HOLD)
      counter_hold_at_terminal_reg <= pwdata[2:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_mask_reg <= LECS_IRQ_RST;
    else if (wr_stb && reg_idx == LECS_IDX_IRQ_MASK)
      irq_mask_reg <= pwdata[2:0];
  end

  // ***********************************************************
  // Interrupt
  // ***********************************************************
  for (genvar et = 0; et < LECS_ERR_TYPES; et++)
  begin : g_irq
    assign irq_set[et] = |hit_vec[et];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_stat_reg <= LECS_IRQ_RST;
    else if (wr_stb && reg_idx == LECS_IDX_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ***********************************************************
  // Checks
  // ***********************************************************
  lane7_map_a: assert property (@(posedge core_clk) disable iff (rst)
    (setup_ph && !pwrite && paddr == {LECS_IDX_LANE7, 2'b00})
    |=> (prdata[LECS_LANE_EN_BIT] == $past(lane7_enabled_flag)
         && prdata[2:0] == $past(lane7_terminal_count_flags) && prdata[31:4] == 28'h0))
    else $error("Lane 7 status read wrong");

  lane6_flags_a: assert property (@(posedge core_clk) disable iff (rst)
    (setup_ph && !pwrite && paddr == {LECS_IDX_LANE6, 2'b00})
    |=> (prdata[LECS_ERR_STRAY] == $past(tc_flag[link_page_reg][LECS_LANE6][LECS_ERR_STRAY])
         && prdata[LECS_ERR_DISP] == $past(tc_flag[link_page_reg][LECS_LANE6][LECS_ERR_DISP])))
    else $error("Lane 6 flag bits misplaced");

  page_select_a: assert property (@(posedge core_clk) disable iff (rst)
    (access_ph && pwrite && paddr == {LECS_IDX_LINK_PAGE, 2'b00})
    |=> (link_page_reg == $past(pwdata[0]))
        ##1 (lane6_enabled_flag == lane_enabled_in[{$past(pwdata[0], 2), 3'(LECS_LANE6)}]))
    else $error("Link page select not applied");

  health_disp_a: assert property (@(posedge core_clk) disable iff (rst)
    (setup_ph && !pwrite && paddr == {LECS_IDX_HEALTH0, 2'b00})
    |=> (prdata[LECS_H_DISP_BIT] ==
         ($past(cnt_val[link_page_reg][LECS_LANE0][LECS_ERR_DISP]) >= $past(error_threshold_reg))))
    else $error("Disparity threshold status wrong");

  health_inval_a: assert property (@(posedge core_clk) disable iff (rst)
    (setup_ph && !pwrite && paddr == {LECS_IDX_HEALTH0, 2'b00})
    |=> (prdata[LECS_H_INVAL_BIT] ==
         ($past(cnt_val[link_page_reg][LECS_LANE0][LECS_ERR_INVAL]) >= $past(error_threshold_reg))))
    else $error("Invalid code threshold status wrong");

  health_stray_a: assert property (@(posedge core_clk) disable iff (rst)
    (setup_ph && !pwrite && paddr == {LECS_IDX_HEALTH0, 2'b00})
    |=> (prdata[LECS_H_STRAY_BIT] ==
         ($past(cnt_val[link_page_reg][LECS_LANE0][LECS_ERR_STRAY]) >= $past(error_threshold_reg))
         && prdata[4:0] == 5'h00))
    else $error("Stray control threshold status wrong");

  term_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    (hit_vec[LECS_ERR_DISP][0]) |=> irq_stat_reg[LECS_ERR_DISP] && tc_flag[0][0][LECS_ERR_DISP])
    else $error("Terminal count event not latched");

  count_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    (clr_req[LECS_ERR_INVAL] && !link_page_reg && !invalid_code_group_error[0])
    |=> (cnt_val[0][0][LECS_ERR_INVAL] == LECS_CNT_ZERO))
    else $error("User counter reset ignored");

  unmapped_err_a: assert property (@(posedge core_clk) disable iff (rst)
    (access_ph && !addr_ok)
    |-> (pslverr && pready)
        ##1 ($stable(link_page_reg) && $stable(error_threshold_reg) && $stable(irq_mask_reg)))
    else $error("Unmapped access not flagged");

  lane6_read_c: cover property (@(posedge core_clk) disable iff (rst)
    setup_ph && !pwrite && paddr == {LECS_IDX_LANE6, 2'b00} && lane6_terminal_count_flags != 3'h0);

  page_one_c: cover property (@(posedge core_clk) disable iff (rst)
    link_page_reg && lane0_disparity_over_threshold);

  hold_term_c: cover property (@(posedge core_clk) disable iff (rst)
    counter_hold_at_terminal_reg[LECS_ERR_STRAY] && cnt_val[1][7][LECS_ERR_STRAY] == LECS_TERM_CNT);

  irq_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(irq));

endmodule // lecs_lane_status

// file: dv/lecs_lane_tx_model.sv
// Serial link transmitter model: error event pulses and lane enables
`timescale 1ns/1ps
module lecs_lane_tx_model
  import lecs_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Commands from bench
  input  wire logic                   fire,
  input  wire logic [1:0]             fire_type,
  input  wire logic [LECS_LN_TOT-1:0] fire_mask,
  input  wire logic [LECS_LN_TOT-1:0] lane_en_cfg,
  // Lane side
  output logic [LECS_LN_TOT-1:0]      running_disparity_error,
  output logic [LECS_LN_TOT-1:0]      invalid_code_group_error,
  output logic [LECS_LN_TOT-1:0]      unexpected_control_char_error,
  output logic [LECS_LN_TOT-1:0]      lane_enabled_in
);
  // ***********************************************************
  // One high cycle per detected error, back to back for consecutive errors
  // ***********************************************************
  always_ff @(posedge core_clk)
  begin
    running_disparity_error       <= (!rst && fire && fire_type == 2'h0) ? fire_mask : '0;
    invalid_code_group_error      <= (!rst && fire && fire_type == 2'h1) ? fire_mask : '0;
    unexpected_control_char_error <= (!rst && fire && fire_type == 2'h2) ? fire_mask : '0;
    lane_enabled_in               <= rst ? '0 : lane_en_cfg;
  end
endmodule // lecs_lane_tx_model

// file: dv/tb.sv
// Self-checking bench for the lane error count and status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb
  import lecs_pkg::*;
;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, pg = 0;
  logic        pready, pslverr, irq, rerr;
  logic [15:0] paddr = 0, fire_mask = 0, lane_en = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [1:0]  fire_type = 0;
  logic [2:0]  hold = 0, ist = 0;
  logic [7:0]  thr = 8'hff;
  logic [7:0]  cnt [3][16];
  logic        flg [3][16];
  logic [LECS_LN_TOT-1:0] running_disparity_error, invalid_code_group_error;
  logic [LECS_LN_TOT-1:0] unexpected_control_char_error, lane_enabled_in;
  int          num_errors = 0, comparisons = 0, seed = 32'h866c;

  always #5 core_clk = ~core_clk;

  lecs_lane_status i_lecs_lane_status (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .running_disparity_error, .invalid_code_group_error, .unexpected_control_char_error,
    .lane_enabled_in, .irq);
  lecs_lane_tx_model i_lecs_lane_tx_model (.core_clk, .rst, .fire, .fire_type, .fire_mask,
    .lane_en_cfg(lane_en), .running_disparity_error, .invalid_code_group_error,
    .unexpected_control_char_error, .lane_enabled_in);

  // ***********************************************************
  // Bus and event tasks
  // ***********************************************************
  task report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20)
    begin
      num_errors++;
      report_and_stop;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
    `CHK("read err", 1'b0, rerr)
  endtask

  task pulse(input int t, input logic [15:0] m, input int n);
    int i, j;
    for (i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      fire <= 1'b1; fire_type <= t[1:0]; fire_mask <= m;
    end
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (3) @(posedge core_clk);
    for (j = 0; j < 16; j++)
      for (i = 0; i < n && m[j]; i++)
      begin
        if (cnt[t][j] == 8'hff) cnt[t][j] = hold[t] ? 8'hff : 8'h00;
        else cnt[t][j]++;
        if (cnt[t][j] == 8'hff) begin flg[t][j] = 1'b1; ist[t] = 1'b1; end
      end
  endtask

  function automatic logic [31:0] lane_exp(input int l);
    int i;
    i = pg * 8 + l;
    return {28'h0, lane_en[i], flg[2][i], flg[1][i], flg[0][i]};
  endfunction

  function automatic logic [31:0] health_exp();
    int i;
    i = pg * 8;
    return {24'h0, cnt[0][i] >= thr, cnt[1][i] >= thr, cnt[2][i] >= thr, 5'h0};
  endfunction

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin #(400us); num_errors++; report_and_stop; end

  initial
  begin
    foreach (cnt[t, l]) begin cnt[t][l] = 8'h00; flg[t][l] = 1'b0; end
    lane_en <= 16'($random(seed));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(16'hc04, 32'hff, "threshold");
    rd(16'hc08, 32'h0, "hold");
    rd(16'hc10, 32'h0, "irq status");
    rd(16'hc14, 32'h0, "irq mask");
    rd(16'hc0c, 32'h0, "clear reads 0");
    rd(16'hc00, 32'h0, "page");
    rd(16'h12c0, health_exp(), "health");
    $display("test reset values done");
    apb(1'b0, 16'h1240, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    apb(1'b1, 16'hc01, 32'h1);
    `CHK("misaligned err", 1'b1, rerr)
    rd(16'hc00, 32'h0, "page kept");
    wr(16'h1258, 32'hf);
    rd(16'h1258, lane_exp(6), "lane6 ro");
    $display("test refused access done");
    for (int p = 0; p < 2; p++)
    begin
      pg = p[0];
      wr(16'hc00, {31'h0, pg});
      rd(16'h1258, lane_exp(6), "lane6 enable");
      rd(16'h125c, lane_exp(7), "lane7 enable");
    end
    $display("test paged enables done");
    repeat (4)
    begin
      pg = 1'($random(seed));
      wr(16'hc00, {31'h0, pg});
      thr = 8'(1 + $unsigned($random(seed)) % 30);
      wr(16'hc04, {24'h0, thr});
      for (int t = 0; t < 3; t++) pulse(t, 16'h1 << (pg * 8), $unsigned($random(seed)) % 20);
      rd(16'h12c0, health_exp(), "health thr");
      wr(16'hc0c, 32'h7);
      foreach (cnt[t, l]) if (l / 8 == pg) begin cnt[t][l] = 8'h00; flg[t][l] = 1'b0; end
      rd(16'h12c0, health_exp(), "health clr");
    end
    $display("test thresholds done");
    pg = 1'b1;
    wr(16'hc00, 32'h1);
    hold = 3'b101;
    wr(16'hc08, {29'h0, hold});
    rd(16'hc08, {29'h0, hold}, "hold set");
    thr = 8'hff;
    wr(16'hc04, 32'hff);
    wr(16'hc14, 32'h2);
    rd(16'hc14, 32'h2, "irq mask set");
    pulse(0, 16'h4100, 256);
    pulse(1, 16'h4100, 255);
    pulse(2, 16'h8000, 254);
    rd(16'h1258, lane_exp(6), "lane6 flags");
    rd(16'h125c, lane_exp(7), "lane7 below");
    pulse(2, 16'h8000, 1);
    rd(16'h125c, lane_exp(7), "lane7 flags");
    rd(16'h12c0, health_exp(), "health held");
    `CHK("irq set", 1'b1, irq)
    pulse(1, 16'h4100, 1);
    rd(16'h12c0, health_exp(), "health wrap");
    rd(16'hc10, {29'h0, ist}, "irq status");
    wr(16'hc10, 32'h2);
    ist[1] = 1'b0;
    rd(16'hc10, {29'h0, ist}, "irq cleared");
    `CHK("irq clear", 1'b0, irq)
    pg = 1'b0;
    wr(16'hc00, 32'h0);
    rd(16'h1258, lane_exp(6), "lane6 page0");
    $display("test terminal count done");
    report_and_stop;
  end
endmodule // tb
